// ===== rtl/upsel_pin_function_select.sv
// file: upper port pin function select register, APB slave and pin routing
`timescale 1ns/1ps
`default_nettype none
module upsel_pin_function_select #(
	parameter bit LARGEST_PACKAGE = 1'b1
) (
	input  wire logic                         core_clk,
	input  wire logic                         nrst,
	input  wire upsel_pkg::upsel_apb_req_t    apbReq,
	output var  upsel_pkg::upsel_apb_rsp_t    apbRsp,
	input  wire logic                         singleChipMode,
	input  wire logic                         noRomCs0Wide,
	input  wire upsel_pkg::upsel_periph_t     periphOut,
	input  wire logic [7:0]                   pinIn,
	output var  upsel_pkg::upsel_pins_t       pinCtl,
	output var  upsel_pkg::upsel_periph_in_t  periphIn,
	output var  logic [15:0]                  upper_port_pin_function_select
);
	typedef struct packed {
		logic [15:0]                 fsel;
		logic [1:0]                  modeS1;
		logic [1:0]                  modeS2;
		logic [7:0]                  pinS1;
		logic [7:0]                  pinS2;
		upsel_pkg::upsel_apb_rsp_t   rsp;
		upsel_pkg::upsel_pins_t      pins;
		upsel_pkg::upsel_periph_in_t pin;
	} upsel_state_t;

	upsel_state_t stQ;
	upsel_state_t stD;
	upsel_pkg::upsel_fn_t fn [8];
	wire  logic [7:0]     periphDrv;
	wire  logic [7:0]     periphIsOut;
	logic [1:0]           code [8];
	logic                 single;
	logic                 wide;
	logic                 apbAccess;
	logic                 hitFsel;
	logic                 hitStatus;

	assign single = stQ.modeS2[0];
	assign wide   = stQ.modeS2[1];

	// one access is taken per transfer: the registered ready blocks a second take
	assign apbAccess = apbReq.psel && apbReq.penable && !stQ.rsp.pready;
	assign hitFsel   = (apbReq.paddr == upsel_pkg::UPSEL_FSEL_OFFSET);
	assign hitStatus = (apbReq.paddr == upsel_pkg::UPSEL_STATUS_OFFSET);

	genvar g;
	generate
		for (g = 0; g < upsel_pkg::UPSEL_PINS; g++) begin : gFn
			// what code 10 leaves on this pin while single chip mode holds
			upsel_pkg::upsel_fn_t singleFn;

			assign code[g] = stQ.fsel[g*upsel_pkg::UPSEL_FIELD_W +: upsel_pkg::UPSEL_FIELD_W];

			if (g == 7) begin : gTrigger
				// input function: the pad is only read, never driven
				assign periphDrv[g]   = 1'b1;
				assign periphIsOut[g] = 1'b0;
				assign singleFn       = upsel_pkg::UPSEL_FN_PERIPH;
			end else if (g == 6) begin : gIrqAccepted
				assign periphDrv[g]   = periphOut.irqAcceptedOutN;
				assign periphIsOut[g] = 1'b1;
				assign singleFn       = upsel_pkg::UPSEL_FN_NONE;
			end else if (g == 5) begin : gChipSel3
				assign periphDrv[g]   = periphOut.chipSelect3N;
				assign periphIsOut[g] = 1'b1;
				assign singleFn       = upsel_pkg::UPSEL_FN_PORT;
			end else if (g == 4) begin : gChipSel2
				assign periphDrv[g]   = periphOut.chipSelect2N;
				assign periphIsOut[g] = 1'b1;
				assign singleFn       = upsel_pkg::UPSEL_FN_PORT;
			end else if (g == 3) begin : gDmaAck1
				assign periphDrv[g]   = periphOut.dmaAckCh1;
				assign periphIsOut[g] = 1'b1;
				assign singleFn       = upsel_pkg::UPSEL_FN_PORT;
			end else if (g == 2) begin : gDmaAck0
				assign periphDrv[g]   = periphOut.dmaAckCh0;
				assign periphIsOut[g] = 1'b1;
				assign singleFn       = upsel_pkg::UPSEL_FN_PORT;
			end else if (g == 1) begin : gDmaReq1
				assign periphDrv[g]   = 1'b1;
				assign periphIsOut[g] = 1'b0;
				assign singleFn       = upsel_pkg::UPSEL_FN_PORT;
			end else begin : gDmaReq0
				assign periphDrv[g]   = 1'b1;
				assign periphIsOut[g] = 1'b0;
				assign singleFn       = upsel_pkg::UPSEL_FN_PORT;
			end

			// no-ROM wide mode is checked first: it wins over single chip mode
			always_comb begin
				fn[g] = upsel_pkg::UPSEL_FN_NONE;
				case (code[g])
					upsel_pkg::UPSEL_CODE_PORT: begin
						if (wide) begin
							fn[g] = upsel_pkg::UPSEL_FN_DATA;
						end else begin
							fn[g] = upsel_pkg::UPSEL_FN_PORT;
						end
					end
					upsel_pkg::UPSEL_CODE_DATA: begin
						if (wide) begin
							fn[g] = upsel_pkg::UPSEL_FN_DATA;
						end else if (single) begin
							fn[g] = upsel_pkg::UPSEL_FN_PORT;
						end else begin
							fn[g] = upsel_pkg::UPSEL_FN_DATA;
						end
					end
					upsel_pkg::UPSEL_CODE_PERIPH: begin
						if (wide) begin
							fn[g] = upsel_pkg::UPSEL_FN_DATA;
						end else if (single) begin
							fn[g] = singleFn;
						end else begin
							fn[g] = upsel_pkg::UPSEL_FN_PERIPH;
						end
					end
					default: begin
						// reserved code: every function of the pin stays off
						fn[g] = upsel_pkg::UPSEL_FN_NONE;
					end
				endcase
				// smaller packages keep the register but have no pins behind it
				if (!LARGEST_PACKAGE) begin
					fn[g] = upsel_pkg::UPSEL_FN_NONE;
				end
			end
		end
	endgenerate

	always_comb begin
		stD = stQ;
		// mode straps come from pins: two flops before use
		stD.modeS1 = {noRomCs0Wide, singleChipMode};
		stD.modeS2 = stQ.modeS1;
		stD.pinS1  = pinIn;
		stD.pinS2  = stQ.pinS1;
		// one-wait slave: pready is registered and rises in the cycle after the first access cycle
		stD.rsp.pready  = apbAccess;
		stD.rsp.pslverr = 1'b0;
		stD.rsp.prdata  = 32'h0000_0000;
		if (apbAccess) begin
			if (hitFsel) begin
				if (apbReq.pwrite) begin
					stD.fsel = apbReq.pwdata[15:0];
				end else begin
					stD.rsp.prdata = {16'h0000, stQ.fsel};
				end
			end else if (hitStatus) begin
				// status is read-only: a write is refused and changes nothing
				stD.rsp.prdata = {30'h0000_0000, stQ.modeS2};
				stD.rsp.pslverr = apbReq.pwrite;
			end else begin
				stD.rsp.pslverr = 1'b1;
			end
		end
		for (int i = 0; i < 8; i++) begin
			stD.pins.portSel[i]   = (fn[i] == upsel_pkg::UPSEL_FN_PORT);
			stD.pins.dataSel[i]   = (fn[i] == upsel_pkg::UPSEL_FN_DATA);
			stD.pins.periphSel[i] = (fn[i] == upsel_pkg::UPSEL_FN_PERIPH);
			stD.pins.periphOe[i]  = (fn[i] == upsel_pkg::UPSEL_FN_PERIPH) && periphIsOut[i];
			stD.pins.periphOut[i] = (fn[i] == upsel_pkg::UPSEL_FN_PERIPH) ? periphDrv[i] : 1'b1;
		end
		// inputs idle high (inactive) unless their pin carries the function
		stD.pin.conversionTriggerInN = (fn[7] == upsel_pkg::UPSEL_FN_PERIPH) ? stQ.pinS2[7] : 1'b1;
		stD.pin.dmaRequestCh1N = (fn[1] == upsel_pkg::UPSEL_FN_PERIPH) ? stQ.pinS2[1] : 1'b1;
		stD.pin.dmaRequestCh0N = (fn[0] == upsel_pkg::UPSEL_FN_PERIPH) ? stQ.pinS2[0] : 1'b1;
	end

	// nrst is the power-on reset only; other resets never reach this register
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			stQ <= '0;
			stQ.fsel <= upsel_pkg::UPSEL_FSEL_RESET;
			stQ.pins.portSel <= 8'hFF;
			stQ.pins.periphOut <= 8'hFF;
			stQ.pin <= 3'h7;
		end else begin
			stQ <= stD;
		end
	end

	assign apbRsp = stQ.rsp;
	assign pinCtl = stQ.pins;
	assign periphIn = stQ.pin;
	assign upper_port_pin_function_select = stQ.fsel;
endmodule : upsel_pin_function_select
`default_nettype wire

// ===== rtl/upsel_pkg.sv
// package: register map, field codes and carrier types for the upper port pin function select
package upsel_pkg;
	localparam logic [11:0] UPSEL_FSEL_OFFSET  = 12'h000;
	localparam logic [11:0] UPSEL_STATUS_OFFSET = 12'h004;
	localparam logic [15:0] UPSEL_FSEL_RESET   = 16'h0000;
	localparam int          UPSEL_FIELD_W      = 2;
	localparam int          UPSEL_PINS         = 8;
	localparam logic [1:0]  UPSEL_CODE_PORT    = 2'h0;
	localparam logic [1:0]  UPSEL_CODE_DATA    = 2'h1;
	localparam logic [1:0]  UPSEL_CODE_PERIPH  = 2'h2;
	localparam logic [1:0]  UPSEL_CODE_RSVD    = 2'h3;

	// resolved function of one pin
	typedef enum logic [3:0] {
		UPSEL_FN_PORT   = 4'h1,
		UPSEL_FN_DATA   = 4'h2,
		UPSEL_FN_PERIPH = 4'h4,
		UPSEL_FN_NONE   = 4'h8
	} upsel_fn_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} upsel_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} upsel_apb_rsp_t;

	// per-pin drive bundle toward the pad ring
	typedef struct packed {
		logic [7:0] portSel;
		logic [7:0] dataSel;
		logic [7:0] periphSel;
		logic [7:0] periphOut;
		logic [7:0] periphOe;
	} upsel_pins_t;

	// internal peripheral signals gated toward the pins
	typedef struct packed {
		logic irqAcceptedOutN;
		logic chipSelect3N;
		logic chipSelect2N;
		logic dmaAckCh1;
		logic dmaAckCh0;
	} upsel_periph_t;

	typedef struct packed {
		logic conversionTriggerInN;
		logic dmaRequestCh1N;
		logic dmaRequestCh0N;
	} upsel_periph_in_t;
endpackage : upsel_pkg

// ===== sim/upsel_monitor.sv
// checker: bus timing and pin decode relations of the function select block
`timescale 1ns/1ps
`default_nettype none
module upsel_monitor (
	input wire logic                      core_clk,
	input wire logic                      nrst,
	input wire upsel_pkg::upsel_apb_req_t apbReq,
	input wire upsel_pkg::upsel_apb_rsp_t apbRsp,
	input wire upsel_pkg::upsel_pins_t    pinCtl,
	input wire logic [15:0]               upper_port_pin_function_select
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence setup_s;
		apbReq.psel && !apbReq.penable ##1 apbReq.psel && apbReq.penable;
	endsequence
	sequence done_s;
		setup_s ##1 apbRsp.pready && apbReq.paddr == 12'h000;
	endsequence
	rst_clear_a: assert property ($rose(nrst) |-> upper_port_pin_function_select == 16'h0000)
		else $error("select not clear after reset");
	wr_take_a: assert property (done_s ##0 apbReq.pwrite |-> upper_port_pin_function_select == apbReq.pwdata[15:0])
		else $error("write not taken");
	rd_data_a: assert property (done_s ##0 !apbReq.pwrite |-> apbRsp.prdata == {16'h0000, upper_port_pin_function_select})
		else $error("read data wrong");
	rdy_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("ready held");
	bad_addr_a: assert property (apbRsp.pready && apbReq.paddr > 12'h004 |-> apbRsp.pslverr) else $error("no error");
	err_keep_a: assert property (apbRsp.pready && apbRsp.pslverr |-> $stable(upper_port_pin_function_select))
		else $error("refused access changed register");
	rsvd_none_a: assert property ($past(upper_port_pin_function_select[15:14]) == 2'h3 |->
		!(pinCtl.portSel[7] || pinCtl.dataSel[7] || pinCtl.periphSel[7])) else $error("reserved code drives pin");
	in_undriven_a: assert property ((pinCtl.periphOe & 8'h83) == 8'h00) else $error("input pin driven");
	oe_follow_a: assert property (pinCtl.periphOe == (pinCtl.periphSel & 8'h7C)) else $error("enable mismatch");
endmodule : upsel_monitor
bind upsel_pin_function_select upsel_monitor u_mon (.core_clk(core_clk), .nrst(nrst), .apbReq(apbReq),
	.apbRsp(apbRsp), .pinCtl(pinCtl), .upper_port_pin_function_select(upper_port_pin_function_select));
`default_nettype wire

// ===== sim/upsel_pin_function_select_bench.sv
// bench: register access and pin routing of the function select block
`timescale 1ns/1ps
`default_nettype none
module upsel_pin_function_select_bench;
	logic                        core_clk;
	logic                        nrst;
	upsel_pkg::upsel_apb_req_t   req;
	upsel_pkg::upsel_apb_rsp_t   rsp;
	logic                        single;
	logic                        noRom;
	upsel_pkg::upsel_periph_t    pOut;
	logic [7:0]                  pinIn;
	upsel_pkg::upsel_pins_t      pins;
	upsel_pkg::upsel_periph_in_t pIn;
	logic [31:0]                 rd;
	logic [15:0]                 fselOut;
	logic [15:0]                 smallFsel;
	upsel_pkg::upsel_pins_t      smallPins;
	logic                        err;
	int                          n_fail;
	int                          num_checks;
	upsel_pin_function_select DUT (.core_clk(core_clk), .nrst(nrst), .apbReq(req), .apbRsp(rsp),
		.singleChipMode(single), .noRomCs0Wide(noRom), .periphOut(pOut), .pinIn(pinIn), .pinCtl(pins),
		.periphIn(pIn), .upper_port_pin_function_select(fselOut));
	// smaller package: same register traffic, no pin may take a function
	upsel_pin_function_select #(.LARGEST_PACKAGE(1'b0)) dutSmall (.core_clk(core_clk), .nrst(nrst),
		.apbReq(req), .apbRsp(), .singleChipMode(single), .noRomCs0Wide(noRom), .periphOut(pOut),
		.pinIn(pinIn), .pinCtl(smallPins), .periphIn(), .upper_port_pin_function_select(smallFsel));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task stop_test;
		if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			n_fail++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	// the idle cycle at the end keeps two requests from landing in one time step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		@(posedge core_clk);
		// no cycle count is assumed: the watchdog ends a wait that never sees ready
		while (rsp.pready !== 1'b1) @(posedge core_clk);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge core_clk);
	endtask : apb
	initial begin
		{n_fail, num_checks, nrst, req, single, noRom} = '0;
		pOut = 5'h16;
		pinIn = 8'h7E;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		chk(pins.portSel, 8'hFF);
		apb(1'b1, 12'h000, 32'hFFFFAAAA);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000AAAA);
		chk(fselOut, 32'h0000AAAA);
		repeat (3) @(posedge core_clk);
		chk(pins.periphSel, 8'hFF);
		chk(pins.periphOut[6:2], 5'h16);
		chk(pIn, 3'h2);
		chk(smallFsel, 16'hAAAA);
		chk({smallPins.portSel, smallPins.dataSel, smallPins.periphSel}, 24'h0);
		apb(1'b1, 12'h000, 32'h5555);
		repeat (3) @(posedge core_clk);
		chk(pins.dataSel, 8'hFF);
		single <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk(pins.portSel, 8'hFF);
		apb(1'b1, 12'h000, 32'hAAAA);
		repeat (3) @(posedge core_clk);
		chk({pins.portSel, pins.periphSel}, 16'h3F80);
		noRom <= 1'b1;
		apb(1'b1, 12'h000, 32'h0);
		repeat (5) @(posedge core_clk);
		chk(pins.dataSel, 8'hFF);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, 12'h004, 32'h0);
		chk(err, 1'h1);
		apb(1'b1, 12'h000, 32'hAAAA);
		repeat (3) @(posedge core_clk);
		chk(pins.dataSel, 8'hFF);
		apb(1'b1, 12'h000, 32'hFFFF);
		repeat (3) @(posedge core_clk);
		chk({pins.portSel, pins.dataSel, pins.periphSel}, 24'h0);
		apb(1'b1, 12'h008, 32'h0);
		chk(err, 1'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000FFFF);
		nrst <= 1'b0;
		@(posedge core_clk);
		chk(fselOut, 16'h0);
		nrst <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		stop_test;
	end
	initial begin
		repeat (2000) @(posedge core_clk);
		n_fail++;
		stop_test;
	end
endmodule : upsel_pin_function_select_bench
`default_nettype wire
